// ---- shared/cexs_pkg.sv ----
`default_nettype none
package cexs_pkg;
  // Address and data widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int VEC_W  = 6;
  // Vector numbers
  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_UNMASK = 6'h07;
  localparam logic [5:0] VEC_TRAP_BASE = 6'h08;
  localparam logic [5:0] VEC_EXT0 = 6'h0c;
  localparam logic [5:0] VEC_EXT1 = 6'h0d;
  localparam logic [5:0] VEC_EXT4 = 6'h10;
  localparam logic [5:0] VEC_EXT5 = 6'h11;
  localparam logic [5:0] VEC_INT_BASE = 6'h14;
  localparam logic [5:0] VEC_INT_LAST = 6'h3c;
  // Source counts
  localparam int N_INT = 25;
  localparam int N_EXT = 4;
  // Condition flag positions
  localparam int CCR_I_BIT  = 7;
  localparam int CCR_AUX_BIT = 6;
  // Reset-entry flag word: main mask set
  localparam logic [7:0] CCR_RESET = 8'h80;
  // Minimum reset low time (system clocks); the pin driver's duty
  localparam int RESET_MIN_CLK = 10;
  // Stack pointer step per pushed word
  localparam logic [23:0] SP_STEP = 24'h000002;
  // Sequencer states, Gray codes along the usual path
  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_PUSH_PC = 3'b001,
    ST_PUSH_CCR = 3'b011,
    ST_VEC_HI = 3'b010,
    ST_VEC_LO = 3'b110,
    ST_RESET = 3'b111
  } cexs_state_t;
  // Exception kind being serviced
  typedef enum logic [1:0] {
    KIND_RESET = 2'b00,
    KIND_IRQ   = 2'b01,
    KIND_TRAP  = 2'b10
  } cexs_kind_t;
endpackage : cexs_pkg
`default_nettype wire

// ---- src/cexs_irq_arb.sv ----
`default_nettype none
// Fixed-priority interrupt arbiter with two priority levels
module cexs_irq_arb (
  input  wire logic [3:0]  ext_req,
  input  wire logic [3:0]  ext_prio,
  input  wire logic [24:0] int_req,
  input  wire logic [24:0] int_prio,
  input  wire logic        unmask_req,
  input  wire logic        mask_main,
  input  wire logic        mask_aux,
  input  wire logic        aux_is_mask,
  output logic             irq_valid,
  output logic [5:0]       irq_vec
);
  logic [28:0] req_all;  // Ext then internal, low index wins
  logic [28:0] pri_all;  // Priority level per source
  logic [5:0]  vec_tab [29];  // Vector per source
  logic [28:0] ok_all;  // Requests passing the masks
  genvar g;
  ////////////////////////////////////////////////////////////////
  assign req_all = {int_req, ext_req};
  assign pri_all = {int_prio, ext_prio};
  assign vec_tab[0] = cexs_pkg::VEC_EXT0;
  assign vec_tab[1] = cexs_pkg::VEC_EXT1;
  assign vec_tab[2] = cexs_pkg::VEC_EXT4;
  assign vec_tab[3] = cexs_pkg::VEC_EXT5;
  // Internal sources take consecutive vectors
  generate
    for (g = 0; g < cexs_pkg::N_INT; g++) begin : g_int
      assign vec_tab[g+4] = cexs_pkg::VEC_INT_BASE + 6'(g);
    end
    // Two-flag masking: low level needs both clear when aux masks
    for (g = 0; g < 29; g++) begin : g_mask
      assign ok_all[g] = req_all[g] && !mask_main &&
        (!pri_all[g] ? !(aux_is_mask && mask_aux) : 1'b1);
    end
  endgenerate
  ////////////////////////////////////////////////////////////////
  // Unmaskable first, then high level, then low level
  always_comb begin
    irq_valid = 1'b0;
    irq_vec   = cexs_pkg::VEC_RESET;
    if (unmask_req) begin  // Ignores masks
      irq_valid = 1'b1;
      irq_vec   = cexs_pkg::VEC_UNMASK;
    end else begin
      for (int i = 28; i >= 0; i--) begin
        if (ok_all[i] && !pri_all[i]) begin
          irq_valid = 1'b1;
          irq_vec   = vec_tab[i];
        end
      end
      for (int i = 28; i >= 0; i--) begin
        if (ok_all[i] && pri_all[i]) begin
          irq_valid = 1'b1;
          irq_vec   = vec_tab[i];
        end
      end
    end
  end
endmodule : cexs_irq_arb
`default_nettype wire

// ---- src/cexs_reset_sync.sv ----
`default_nettype none
// Two-stage capture of the chip clear pin plus watchdog merge
module cexs_reset_sync (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic chip_clear_pin_n,
  input  wire logic wdt_overflow,
  output logic      in_reset
);
  logic meta_reg;  // First stage, read only by second
  logic sync_reg;  // Second stage
  logic meta_next;
  logic sync_next;
  ////////////////////////////////////////////////////////////////
  always_comb begin
    meta_next = chip_clear_pin_n;
    sync_next = meta_reg;
  end
  // Pin is asynchronous; two flops before use
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end
  // Watchdog overflow acts like the pin
  assign in_reset = !sync_reg || wdt_overflow;
endmodule : cexs_reset_sync
`default_nettype wire

// ---- src/cexs_seq.sv ----
`default_nettype none
// Functional notes
// - Priority: reset, then interrupt, then trap
// - Reset sequence starts on clear-pin release
// - Interrupts taken only at instruction boundary
// - Trap taken while running unless an interrupt is taken that cycle, ignores masks
// - Trap/irq: push PC, flags, mask, vector
// - Reset skips stacking, masks, fetches vector
// - Fixed vector numbers per source
// - Vector entry two or four bytes
// - Held in reset: halt and initialize state
// - Release: set mask, read vector zero
// - No interrupt accepted right after reset
// - First instruction always runs after reset
// - Watchdog overflow resets like the pin
// - Five external and 25 internal sources
// - Unmaskable request ignores mask bits
// - Two priority levels, arbitrated
// - Trap number 0..3 picks vector
// - Select bit clear makes aux flag a mask
// - Stack word address bit zero forced low
module cexs_seq (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        chip_clear_pin_n,
  input  wire logic        wdt_overflow,
  input  wire logic        advanced_mode,
  input  wire logic        user_flag_select,
  input  wire logic        unmask_req,
  input  wire logic [3:0]  ext_req,
  input  wire logic [3:0]  ext_prio,
  input  wire logic [24:0] int_req,
  input  wire logic [24:0] int_prio,
  input  wire logic        insn_boundary,
  input  wire logic        soft_vector_call,
  input  wire logic [1:0]  trap_num,
  input  wire logic [23:0] cur_pc,
  input  wire logic [7:0]  cond_flags_word,
  input  wire logic [23:0] stack_ptr,
  input  wire logic        mem_ready,
  input  wire logic [15:0] mem_rdata,
  output logic             periph_clear,
  output logic             pipe_hold,
  output logic             pc_load,
  output logic [23:0]      pc_value,
  output logic             ccr_load,
  output logic [7:0]       ccr_value,
  output logic             sp_load,
  output logic [23:0]      sp_value,
  output logic             mem_req,
  output logic             mem_we,
  output logic [23:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  output logic             unmask_ack,
  output logic             irq_ack,
  output logic [5:0]       irq_ack_vec
);
  cexs_pkg::cexs_state_t state_reg, state_next;  // Sequencer state
  cexs_pkg::cexs_kind_t  kind_reg, kind_next;    // Exception in service
  logic [5:0]  vec_reg, vec_next;        // Vector number latched
  logic [23:0] sp_reg, sp_next;          // Working stack pointer
  logic [23:0] pc_reg, pc_next;          // Saved PC
  logic [7:0]  ccr_reg, ccr_next;        // Saved flag word
  logic [15:0] vhi_reg, vhi_next;        // Upper vector half
  logic        boot_reg, boot_next;      // Blocks irq until 1st insn
  logic        pcl_reg, pcl_next;        // PC load strobe
  logic [23:0] pcv_reg, pcv_next;        // PC value
  logic        ccl_reg, ccl_next;        // Flag load strobe
  logic [7:0]  ccv_reg, ccv_next;        // Flag value
  logic        spl_reg, spl_next;        // SP load strobe
  logic        ack_reg, ack_next;        // Interrupt ack strobe
  logic        nack_reg, nack_next;      // Unmaskable ack strobe
  logic        in_reset;                 // Pin or watchdog reset
  logic        irq_valid;                // Arbiter has a winner
  logic [5:0]  irq_vec;                  // Winning vector
  logic [23:0] vaddr;                    // Vector entry address
  logic [23:0] sp_even;                  // Stack address, bit 0 low
  ////////////////////////////////////////////////////////////////
  cexs_reset_sync cexs_reset_sync_inst (
    .ref_clk          (ref_clk),
    .srst             (srst),
    .chip_clear_pin_n (chip_clear_pin_n),
    .wdt_overflow     (wdt_overflow),
    .in_reset         (in_reset)
  );
  // Five external lines incl. unmaskable, 25 internal
  cexs_irq_arb cexs_irq_arb_inst (
    .ext_req     (ext_req),
    .ext_prio    (ext_prio),
    .int_req     (int_req),
    .int_prio    (int_prio),
    .unmask_req  (unmask_req),
    .mask_main   (cond_flags_word[cexs_pkg::CCR_I_BIT]),
    .mask_aux    (cond_flags_word[cexs_pkg::CCR_AUX_BIT]),
    .aux_is_mask (!user_flag_select),
    .irq_valid   (irq_valid),
    .irq_vec     (irq_vec)
  );
  ////////////////////////////////////////////////////////////////
  // Entry size 2 or 4 bytes, low 16 bits only
  always_comb begin
    vaddr = '0;
    if (advanced_mode) begin
      vaddr[15:0] = {8'h00, vec_reg, 2'b00};
    end else begin
      vaddr[15:0] = {9'h000, vec_reg, 1'b0};
    end
  end
  assign sp_even = {sp_reg[23:1], 1'b0};
  ////////////////////////////////////////////////////////////////
  // Next-state logic of the sequencer
  always_comb begin
    state_next = state_reg;
    kind_next  = kind_reg;
    vec_next   = vec_reg;
    sp_next    = sp_reg;
    pc_next    = pc_reg;
    ccr_next   = ccr_reg;
    vhi_next   = vhi_reg;
    boot_next  = boot_reg;
    pcl_next   = 1'b0;
    pcv_next   = pcv_reg;
    ccl_next   = 1'b0;
    ccv_next   = ccv_reg;
    spl_next   = 1'b0;
    ack_next   = 1'b0;
    nack_next  = 1'b0;
    mem_req    = 1'b0;
    mem_we     = 1'b0;
    mem_addr   = '0;
    mem_wdata  = '0;
    if (in_reset) begin
      // Halt everything while held
      state_next = cexs_pkg::ST_RESET;
      kind_next  = cexs_pkg::KIND_RESET;
      vec_next   = cexs_pkg::VEC_RESET;
      boot_next  = 1'b1;
    end else begin
      unique case (state_reg)
        cexs_pkg::ST_RESET: begin
          // Release: mask set, no stacking
          ccl_next   = 1'b1;
          ccv_next   = cexs_pkg::CCR_RESET;
          state_next = cexs_pkg::ST_VEC_HI;
        end
        cexs_pkg::ST_RUN: begin
          if (boot_reg && insn_boundary) begin
            boot_next = 1'b0;  // First insn done
          end
          if (insn_boundary && irq_valid && !boot_reg) begin
            // Taken between instructions
            kind_next  = cexs_pkg::KIND_IRQ;
            vec_next   = irq_vec;
            ack_next   = (irq_vec != cexs_pkg::VEC_UNMASK);
            nack_next  = (irq_vec == cexs_pkg::VEC_UNMASK);
            pc_next    = cur_pc;
            ccr_next   = cond_flags_word;
            sp_next    = stack_ptr;
            state_next = cexs_pkg::ST_PUSH_PC;
          end else if (soft_vector_call) begin
            // No mask
            kind_next  = cexs_pkg::KIND_TRAP;
            vec_next   = cexs_pkg::VEC_TRAP_BASE + {4'h0, trap_num};
            pc_next    = cur_pc;
            ccr_next   = cond_flags_word;
            sp_next    = stack_ptr;
            state_next = cexs_pkg::ST_PUSH_PC;
          end
        end
        cexs_pkg::ST_PUSH_PC: begin
          // PC low word then flags+PC high word
          mem_req   = 1'b1;
          mem_we    = 1'b1;
          mem_addr  = sp_even - cexs_pkg::SP_STEP;
          mem_wdata = pc_reg[15:0];
          if (mem_ready) begin
            sp_next    = sp_even - cexs_pkg::SP_STEP;
            state_next = cexs_pkg::ST_PUSH_CCR;
          end
        end
        cexs_pkg::ST_PUSH_CCR: begin
          mem_req   = 1'b1;
          mem_we    = 1'b1;
          mem_addr  = sp_even - cexs_pkg::SP_STEP;
          mem_wdata = {ccr_reg, pc_reg[23:16]};
          if (mem_ready) begin
            sp_next    = sp_even - cexs_pkg::SP_STEP;
            spl_next   = 1'b1;
            ccl_next   = 1'b1;
            ccv_next   = ccr_reg;
            ccv_next[cexs_pkg::CCR_I_BIT] = 1'b1;
            if (kind_reg == cexs_pkg::KIND_TRAP && !user_flag_select) begin
              ccv_next[cexs_pkg::CCR_AUX_BIT] = 1'b1;
            end
            state_next = cexs_pkg::ST_VEC_HI;
          end
        end
        cexs_pkg::ST_VEC_HI: begin
          // First entry word; the whole entry in normal mode
          mem_req  = 1'b1;
          mem_addr = vaddr;
          if (mem_ready) begin
            vhi_next   = mem_rdata;
            if (advanced_mode) begin
              state_next = cexs_pkg::ST_VEC_LO;
            end else begin
              pcl_next   = 1'b1;
              pcv_next   = {8'h00, mem_rdata};
              state_next = cexs_pkg::ST_RUN;
            end
          end
        end
        cexs_pkg::ST_VEC_LO: begin
          mem_req  = 1'b1;
          mem_addr = vaddr + cexs_pkg::SP_STEP;
          if (mem_ready) begin
            pcl_next   = 1'b1;
            pcv_next   = {vhi_reg[7:0], mem_rdata};
            state_next = cexs_pkg::ST_RUN;
          end
        end
        default: begin
          state_next = cexs_pkg::ST_RESET;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // State registers only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= cexs_pkg::ST_RESET;
      kind_reg  <= cexs_pkg::KIND_RESET;
      vec_reg   <= cexs_pkg::VEC_RESET;
      sp_reg    <= '0;
      pc_reg    <= '0;
      ccr_reg   <= '0;
      vhi_reg   <= '0;
      boot_reg  <= 1'b1;
      pcl_reg   <= 1'b0;
      pcv_reg   <= '0;
      ccl_reg   <= 1'b0;
      ccv_reg   <= '0;
      spl_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      nack_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
      vec_reg   <= vec_next;
      sp_reg    <= sp_next;
      pc_reg    <= pc_next;
      ccr_reg   <= ccr_next;
      vhi_reg   <= vhi_next;
      boot_reg  <= boot_next;
      pcl_reg   <= pcl_next;
      pcv_reg   <= pcv_next;
      ccl_reg   <= ccl_next;
      ccv_reg   <= ccv_next;
      spl_reg   <= spl_next;
      ack_reg   <= ack_next;
      nack_reg  <= nack_next;
    end
  end
  ////////////////////////////////////////////////////////////////
  assign periph_clear = in_reset;  // Peripherals cleared
  assign pipe_hold    = (state_reg != cexs_pkg::ST_RUN);
  assign pc_load      = pcl_reg;
  assign pc_value     = pcv_reg;
  assign ccr_load     = ccl_reg;
  assign ccr_value    = ccv_reg;
  assign sp_load      = spl_reg;
  assign sp_value     = sp_reg;
  assign unmask_ack   = nack_reg;
  assign irq_ack      = ack_reg;
  assign irq_ack_vec  = vec_reg;
  ////////////////////////////////////////////////////////////////
  // Checks watch only what this block drives; pin timing is the driver's
  chk_reset_halts: assert property (
    @(posedge ref_clk) disable iff (srst)
    in_reset |=> state_reg == cexs_pkg::ST_RESET && !mem_we)
    else $error("reset did not halt");
  chk_reset_nostack: assert property (
    @(posedge ref_clk) disable iff (srst)
    state_reg == cexs_pkg::ST_RESET && !in_reset
    |=> state_reg == cexs_pkg::ST_VEC_HI && ccl_reg
        && ccv_reg == cexs_pkg::CCR_RESET)
    else $error("reset entry wrong");
  chk_reset_fetch: assert property (
    @(posedge ref_clk) disable iff (srst)
    state_reg == cexs_pkg::ST_RESET && !in_reset
    |=> mem_req && !mem_we && mem_addr == '0)
    else $error("reset vector not read");
  chk_vec_addr: assert property (
    @(posedge ref_clk) disable iff (srst)
    state_reg == cexs_pkg::ST_VEC_HI
    |-> mem_addr == (24'(vec_reg) << (advanced_mode ? 2 : 1)))
    else $error("vector address wrong");
  chk_stack_even: assert property (
    @(posedge ref_clk) disable iff (srst)
    mem_we |-> !mem_addr[0])
    else $error("odd stack address");
  chk_boot_block: assert property (
    @(posedge ref_clk) disable iff (srst)
    boot_reg |=> !ack_reg && !nack_reg)
    else $error("irq after reset");
  chk_trap_vec: assert property (
    @(posedge ref_clk) disable iff (srst)
    state_reg == cexs_pkg::ST_RUN && !in_reset && soft_vector_call
    && !(insn_boundary && irq_valid && !boot_reg)
    |=> kind_reg == cexs_pkg::KIND_TRAP
        && vec_reg == cexs_pkg::VEC_TRAP_BASE + {4'h0, $past(trap_num)})
    else $error("trap vector wrong");
  chk_irq_first: assert property (
    @(posedge ref_clk) disable iff (srst)
    state_reg == cexs_pkg::ST_RUN && !in_reset && insn_boundary
    && irq_valid && !boot_reg |=> kind_reg == cexs_pkg::KIND_IRQ)
    else $error("priority wrong");
  chk_mask_set: assert property (
    @(posedge ref_clk) disable iff (srst)
    ccl_reg |-> ccv_reg[cexs_pkg::CCR_I_BIT])
    else $error("mask not set");
  cov_irq: cover property (@(posedge ref_clk) ack_reg);
  cov_nmi: cover property (@(posedge ref_clk) nack_reg);
  cov_trap: cover property (@(posedge ref_clk)
    kind_reg == cexs_pkg::KIND_TRAP && pcl_reg);
endmodule : cexs_seq
`default_nettype wire

// ---- sim/cexs_mem_model.sv ----
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Stack and vector memory at the far side of the sequencer
module cexs_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [1:0]  lat,
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_addr,
  output logic             mem_ready,
  output logic [15:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] wait_cnt;  // Wait states spent on current access

  // Answer after lat wait states; data pattern comes from the address
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mem_ready <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_cnt  <= 2'h0;
    end else if (mem_req && !mem_ready && wait_cnt >= lat) begin
      mem_ready <= 1'b1;
      mem_rdata <= {mem_addr[7:0] ^ 8'ha5, mem_addr[7:0]};
      wait_cnt  <= 2'h0;
    end else begin
      // Idle bus flips every cycle so stale data never passes
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= (mem_req && !mem_ready) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule : cexs_mem_model
`default_nettype wire

// ---- sim/test_cpu_exception_sequencer.sv ----
`default_nettype none
module test_cpu_exception_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  logic        ref_clk = 1'b0, srst = 1'b1;
  logic        chip_clear_pin_n = 1'b0, wdt_overflow = 1'b0;
  logic        advanced_mode = 1'b0, user_flag_select = 1'b1;
  logic        unmask_req = 1'b0, insn_boundary = 1'b0;
  logic        soft_vector_call = 1'b0;
  logic [1:0]  trap_num = 2'h0, lat = 2'h0;
  logic [3:0]  ext_req = 4'h0, ext_prio = 4'h0;
  logic [24:0] int_req = 25'h0, int_prio = 25'h0;
  logic [23:0] cur_pc = 24'h123456, stack_ptr = 24'h00ff10;
  logic [7:0]  cond_flags_word = 8'h00;
  logic        mem_ready, periph_clear, pipe_hold, pc_load, ccr_load;
  logic        sp_load, mem_req, mem_we, unmask_ack, irq_ack;
  logic [15:0] mem_rdata, mem_wdata;
  logic [23:0] pc_value, sp_value, mem_addr;
  logic [7:0]  ccr_value;
  logic [5:0]  irq_ack_vec;
  // Captured traffic of one exception
  logic [23:0] wa[$], ra[$], pc_s, sp_s;
  logic [15:0] wd[$];
  logic [7:0]  ccr_s;
  logic [5:0]  ack_v;
  int          pc_n, ack_n, un_n, err_total, comparisons;
  // Vectors of lines 0, 1, 4, 5
  logic [5:0]  ev [4] = '{6'h0c, 6'h0d, 6'h10, 6'h11};

  always #2.5 ref_clk = ~ref_clk;

  cexs_seq cexs_seq_inst (.ref_clk, .srst, .chip_clear_pin_n,
    .wdt_overflow, .advanced_mode, .user_flag_select, .unmask_req,
    .ext_req, .ext_prio, .int_req, .int_prio, .insn_boundary,
    .soft_vector_call, .trap_num, .cur_pc, .cond_flags_word,
    .stack_ptr, .mem_ready, .mem_rdata, .periph_clear, .pipe_hold,
    .pc_load, .pc_value, .ccr_load, .ccr_value, .sp_load, .sp_value,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .unmask_ack, .irq_ack,
    .irq_ack_vec);

  cexs_mem_model cexs_mem_model_inst (.ref_clk, .srst, .lat, .mem_req,
    .mem_addr, .mem_ready, .mem_rdata);

  // Monitor: log accesses and strobes at each edge
  always @(posedge ref_clk) begin
    if (mem_req && mem_ready && mem_we) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_wdata);
    end
    if (mem_req && mem_ready && !mem_we) ra.push_back(mem_addr);
    if (ccr_load) ccr_s = ccr_value;
    if (sp_load) sp_s = sp_value;
    if (pc_load) begin
      pc_s = pc_value;
      pc_n++;
    end
    if (irq_ack) begin
      ack_v = irq_ack_vec;
      ack_n++;
    end
    if (unmask_ack) un_n++;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  // Same pattern the memory partner serves
  function automatic logic [15:0] vd(input logic [23:0] a);
    return {a[7:0] ^ 8'ha5, a[7:0]};
  endfunction : vd

  task automatic clr_log;
    wa.delete();
    wd.delete();
    ra.delete();
    pc_n = 0;
    ack_n = 0;
    un_n = 0;
    {pc_s, sp_s, ccr_s} = 'x;
  endtask : clr_log

  // Wait for the new PC; upstream drops requests once answered
  task automatic expect_seq(input bit adv, input logic [5:0] vec,
                            input bit stk, input logic [7:0] ccr_e);
    int          i;
    logic [23:0] va, pc_e, a2, a4;
    logic [31:0] two;
    for (i = 0; i < 400 && pc_n < 1; i++) begin
      @(posedge ref_clk);
      if (irq_ack) begin
        ext_req <= 4'h0;
        int_req <= 25'h0;
      end
      if (unmask_ack) unmask_req <= 1'b0;
      if (pipe_hold) soft_vector_call <= 1'b0;
      insn_boundary <= 1'b0;
    end
    va = adv ? {16'h0, vec, 2'h0} : {17'h0, vec, 1'h0};
    two = {vd(va), vd(va + 24'h000002)};
    pc_e = adv ? two[23:0] : {8'h00, vd(va)};
    a2 = stack_ptr - 24'h000002;
    a4 = stack_ptr - 24'h000004;
    chk("pc load count", pc_n, 1);
    chk("vector addr", ra[0], va);
    chk("read count", ra.size(), adv ? 2 : 1);
    if (adv) chk("vector addr lo", ra[1], va + 24'h000002);
    chk("new pc", pc_s, pc_e);
    chk("flags", ccr_s, ccr_e);
    chk("write count", wa.size(), stk ? 2 : 0);
    if (stk) begin
      chk("push pc addr", wa[0], {a2[23:1], 1'b0});
      chk("push pc data", wd[0], cur_pc[15:0]);
      chk("push flag addr", wa[1], {a4[23:1], 1'b0});
      chk("push flag data", wd[1],
          {cond_flags_word, cur_pc[23:16]});
      chk("new sp", sp_s, {a4[23:1], 1'b0});
    end
    if (vec >= 6'h0c) chk("ack vector", ack_v, vec);
    if (vec == 6'h07) chk("unmask ack", un_n, 1);
    if (vec[5:2] == 4'h2) chk("no irq ack", ack_n, 0);
  endtask : expect_seq

  // Raise requests together with an instruction boundary
  task automatic fire(input bit adv, input bit sel,
                      input logic [7:0] fl, input logic [23:0] sp,
                      input logic [3:0] ext, input logic [24:0] intr,
                      input bit un, input bit trap,
                      input logic [1:0] tn);
    @(posedge ref_clk);
    clr_log();
    advanced_mode <= adv;
    user_flag_select <= sel;
    cond_flags_word <= fl;
    stack_ptr <= sp;
    ext_req <= ext;
    int_req <= intr;
    unmask_req <= un;
    soft_vector_call <= trap;
    trap_num <= tn;
    lat <= tn;
    insn_boundary <= 1'b1;
  endtask : fire
  ////////////////////////////////////////
  // Pin or watchdog reset, held past the minimum low time
  task automatic t_reset(input bit adv, input bit wdt);
    @(posedge ref_clk);
    clr_log();
    advanced_mode <= adv;
    if (wdt) wdt_overflow <= 1'b1;
    else chip_clear_pin_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk("periph clear", periph_clear, 1'b1);
    chk("held", pipe_hold, 1'b1);
    wdt_overflow <= 1'b0;
    chip_clear_pin_n <= 1'b1;
    expect_seq(adv, 6'h00, 1'b0, 8'h80);
  endtask : t_reset

  // Unmaskable request waiting across reset waits one instruction
  task automatic t_first;
    @(posedge ref_clk);
    unmask_req <= 1'b1;
    t_reset(1'b0, 1'b0);
    @(posedge ref_clk);
    insn_boundary <= 1'b1;
    @(posedge ref_clk);
    insn_boundary <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("early unmask ack", un_n, 0);
    fire(0, 1, 8'h80, 24'h00ff10, 4'h0, 25'h0, 1, 0, 2'h1);
    expect_seq(0, 6'h07, 1, 8'h80);
  endtask : t_first
  ////////////////////////////////////////
  // Hang guard: whole run needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    t_first();
    // Masked traps, select 0: both mask bits set
    for (int n = 0; n < 4; n++) begin
      fire(0, 0, 8'h80, 24'h00ff10, 4'h0, 25'h0, 0, 1, n[1:0]);
      expect_seq(0, 6'h08 + n[5:0], 1, 8'hc0);
    end
    fire(1, 1, 8'h00, 24'h00ff10, 4'h0, 25'h0, 0, 1, 2'h3);
    expect_seq(1, 6'h0b, 1, 8'h80);
    for (int i = 0; i < 4; i++) begin
      fire(1, 1, 8'h00, 24'h00ff10, 4'h1 << i, 25'h0, 0, 0, 2'h2);
      expect_seq(1, ev[i], 1, 8'h80);
    end
    fire(0, 1, 8'h00, 24'h00ff10, 4'h0, 25'h0000001, 0, 0, 2'h0);
    expect_seq(0, 6'h14, 1, 8'h80);
    fire(0, 1, 8'h00, 24'h00ff10, 4'h0, 25'h1000000, 0, 0, 2'h1);
    expect_seq(0, 6'h2c, 1, 8'h80);
    // Interrupt beats a trap raised in the same cycle
    fire(0, 1, 8'h00, 24'h00ff10, 4'h1, 25'h0, 0, 1, 2'h1);
    expect_seq(0, 6'h0c, 1, 8'h80);
    // High-level internal source beats low-level line 0
    @(posedge ref_clk);
    int_prio <= 25'h0000008;
    fire(0, 1, 8'h00, 24'h00ff10, 4'h1, 25'h0000008, 0, 0, 2'h2);
    expect_seq(0, 6'h17, 1, 8'h80);
    // Odd stack pointer: word pushes land on even addresses
    fire(0, 1, 8'h00, 24'h00ff11, 4'h0, 25'h0, 0, 1, 2'h0);
    expect_seq(0, 6'h08, 1, 8'h80);
    // Aux flag as mask blocks a low-level line, so the trap goes ahead
    fire(0, 0, 8'h40, 24'h00ff10, 4'h1, 25'h0, 0, 1, 2'h2);
    expect_seq(0, 6'h0a, 1, 8'hc0);
    t_reset(1'b1, 1'b1);
    finish_test();
  end
endmodule : test_cpu_exception_sequencer
`default_nettype wire
